// ### src/sbcr_pkg.sv
// constants, register map and field layouts of the spi register bank
// Notes on behaviour
// - frame bit 7 low reads; reading a read/clear flag register clears its flags
// - frame bit 7 high writes data byte
// - power-on or soft reset loads defaults
// - restart loads restart values, x bits kept
// - control bits other than the hardware-updatable ones change only by spi
// - hardware-updatable bits change, reads show them
// - mode field 11 executes a soft reset
// - restart forces mode field to normal
package sbcr_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
	localparam logic [CNT_W-1:0] CNT_OVER = 5'h11;
	localparam int RW_BIT = 7;
	localparam int ADDR_MSB = 6;
	localparam int DATA_LSB = 8;
	localparam int IDX_W = 5;
	localparam int NREG = 32;
	localparam logic [6:0] A_MODE_SUPPLY = 7'h01;
	localparam logic [6:0] A_FAIL_OUT = 7'h02;
	localparam logic [6:0] A_WDOG = 7'h03;
	localparam logic [6:0] A_XCVR = 7'h04;
	localparam logic [6:0] A_WAKE_A = 7'h06;
	localparam logic [6:0] A_WAKE_B = 7'h07;
	localparam logic [6:0] A_WAKE_PULL = 7'h08;
	localparam logic [6:0] A_WAKE_FILT = 7'h09;
	localparam logic [6:0] A_TIMER_A = 7'h0c;
	localparam logic [6:0] A_TIMER_B = 7'h0d;
	localparam logic [6:0] A_SW_SD = 7'h10;
	localparam logic [6:0] A_LOW_SIDE = 7'h12;
	localparam logic [6:0] A_HIGH_A = 7'h14;
	localparam logic [6:0] A_HIGH_B = 7'h15;
	localparam logic [6:0] A_HIGH_C = 7'h16;
	localparam logic [6:0] A_DUTY_A = 7'h18;
	localparam logic [6:0] A_DUTY_B = 7'h19;
	localparam logic [6:0] A_DUTY_C = 7'h1a;
	localparam logic [6:0] A_DUTY_D = 7'h1b;
	localparam logic [6:0] A_PWM_FREQ = 7'h1c;
	localparam logic [6:0] A_SCRATCH = 7'h1e;
	localparam logic [6:0] A_SUPPLY_FLG = 7'h41;
	localparam logic [6:0] A_THERM_FLG = 7'h42;
	localparam logic [6:0] A_DEV_FLG = 7'h43;
	localparam logic [6:0] A_XCVR_FLG = 7'h44;
	localparam logic [6:0] A_WAKE_FLG = 7'h46;
	localparam logic [6:0] A_WAKE_LVL = 7'h48;
	localparam logic [6:0] A_LS_OVL_FLG = 7'h52;
	localparam logic [6:0] A_HS_OVL_FLG = 7'h54;
	localparam logic [6:0] A_HS_OPEN_FLG = 7'h55;
	localparam logic [6:0] A_IDENTITY = 7'h7e;
	// status registers all sit above this base; flag array drops it
	localparam logic [6:0] STATUS_BASE = 7'h40;
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SOFT_RST = 2'h3;
	localparam logic [7:0] VCC2_ON_BITS = 8'h18;
	localparam logic [7:0] WD_STOP_EN_BIT = 8'h40;
	localparam logic [7:0] WAKE_STOP_EN_BIT = 8'h04;
	localparam logic [7:0] WDOG_DEFAULT = 8'h10;
	localparam logic [7:0] SUPPLY_POR_FLAG = 8'h80;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;

	// writable bits of a control register, reserved bits stay zero
	function automatic logic [7:0] sbcr_wmask(input logic [6:0] a);
		case (a)
			A_MODE_SUPPLY: sbcr_wmask = 8'hdb;
			A_FAIL_OUT: sbcr_wmask = 8'h20;
			A_WDOG: sbcr_wmask = 8'h57;
			A_XCVR: sbcr_wmask = 8'hfb;
			A_WAKE_A: sbcr_wmask = 8'hcc;
			A_WAKE_B: sbcr_wmask = 8'h3f;
			A_WAKE_PULL, A_WAKE_FILT: sbcr_wmask = 8'hff;
			A_TIMER_A, A_TIMER_B, A_SW_SD: sbcr_wmask = 8'h77;
			A_LOW_SIDE: sbcr_wmask = 8'h03;
			A_HIGH_A: sbcr_wmask = 8'hff;
			A_HIGH_B, A_HIGH_C: sbcr_wmask = 8'h77;
			A_DUTY_A, A_DUTY_B, A_DUTY_C, A_DUTY_D: sbcr_wmask = 8'hff;
			A_PWM_FREQ: sbcr_wmask = 8'h55;
			A_SCRATCH: sbcr_wmask = 8'hff;
			default: sbcr_wmask = 8'h00;
		endcase
	endfunction

	// bits that keep their contents on restart ('x' bits)
	function automatic logic [7:0] sbcr_keep(input logic [6:0] a);
		case (a)
			A_MODE_SUPPLY: sbcr_keep = 8'h03;
			A_WDOG: sbcr_keep = 8'h17;
			A_FAIL_OUT, A_LOW_SIDE: sbcr_keep = 8'h00;
			A_HIGH_A, A_HIGH_B, A_HIGH_C: sbcr_keep = 8'h00;
			default: sbcr_keep = 8'hff;
		endcase
	endfunction

	function automatic logic [7:0] sbcr_default(input logic [6:0] a);
		sbcr_default = (a == A_WDOG) ? WDOG_DEFAULT : BYTE_ZERO;
	endfunction

	// flag bits that exist in a read/clear register
	function automatic logic [7:0] sbcr_fmask(input logic [6:0] a);
		case (a)
			A_SUPPLY_FLG, A_DEV_FLG, A_WAKE_FLG: sbcr_fmask = 8'hff;
			A_THERM_FLG: sbcr_fmask = 8'h1f;
			A_XCVR_FLG: sbcr_fmask = 8'h67;
			A_LS_OVL_FLG: sbcr_fmask = 8'h03;
			A_HS_OVL_FLG, A_HS_OPEN_FLG: sbcr_fmask = 8'h3f;
			default: sbcr_fmask = 8'h00;
		endcase
	endfunction

	function automatic logic sbcr_is_ctrl(input logic [6:0] a);
		sbcr_is_ctrl = (sbcr_wmask(a) != BYTE_ZERO);
	endfunction

	function automatic logic sbcr_is_flag(input logic [6:0] a);
		sbcr_is_flag = (sbcr_fmask(a) != BYTE_ZERO);
	endfunction
endpackage

// ### src/sbcr_register_bank.sv
// spi-addressed control and status register bank of the basis chip
`timescale 1ns/1ps
`default_nettype none
module sbcr_register_bank
	import sbcr_pkg::*;
#(
	// family and product codes: arbitrary neutral values
	parameter logic [3:0] FAMILY_CODE = 4'h1,
	parameter logic [3:0] PRODUCT_CODE = 4'h2
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic SCLK,
	input wire logic CSN,
	input wire logic SDI,
	output logic SDO,
	output logic SDO_OE,
	input wire logic RESTART,
	input wire logic VCC2_OFF,
	input wire logic WD_STOP_CLR,
	input wire logic [7:0] SUPPLY_EVT,
	input wire logic [7:0] THERMAL_EVT,
	input wire logic [7:0] DEVICE_EVT,
	input wire logic [7:0] XCVR_EVT,
	input wire logic [7:0] WAKE_EVT,
	input wire logic [7:0] LS_OVL_EVT,
	input wire logic [7:0] HS_OVL_EVT,
	input wire logic [7:0] HS_OPEN_EVT,
	input wire logic [7:0] WAKE_LVL,
	output logic SOFT_RESET,
	output logic [7:0] MODE_SUPPLY_CONTROL,
	output logic [7:0] FAILURE_OUTPUT_CONTROL,
	output logic [7:0] WINDOW_WATCHDOG_CONTROL,
	output logic [7:0] TRANSCEIVER_CONTROL,
	output logic [7:0] WAKE_SOURCE_CONTROL_A,
	output logic [7:0] WAKE_SOURCE_CONTROL_B,
	output logic [7:0] WAKE_PULL_CONFIG,
	output logic [7:0] WAKE_FILTER_CONFIG,
	output logic [7:0] CYCLIC_TIMER_A_CONTROL,
	output logic [7:0] CYCLIC_TIMER_B_CONTROL,
	output logic [7:0] SWITCH_SHUTDOWN_CONTROL,
	output logic [7:0] LOW_SIDE_SWITCH_CONTROL,
	output logic [7:0] HIGH_SIDE_SWITCH_CONTROL_A,
	output logic [7:0] HIGH_SIDE_SWITCH_CONTROL_B,
	output logic [7:0] HIGH_SIDE_SWITCH_CONTROL_C,
	output logic [7:0] DUTY_CYCLE_CHANNEL_A,
	output logic [7:0] DUTY_CYCLE_CHANNEL_B,
	output logic [7:0] DUTY_CYCLE_CHANNEL_C,
	output logic [7:0] DUTY_CYCLE_CHANNEL_D,
	output logic [7:0] MODULATION_FREQUENCY_SELECT,
	output logic [7:0] SYSTEM_SCRATCH_STATUS
);

	// link side, clocked by the master's serial clock
	logic active;
	logic [CNT_W-1:0] rx_cnt;
	logic [FRAME_BITS-1:0] rx_frame;
	logic [3:0] tx_idx;

	// core side
	logic csn_s1;
	logic csn_s2;
	logic csn_d;
	logic [7:0] lvl_s1;
	logic [7:0] lvl_s2;
	logic take;
	logic [6:0] addr;
	logic [IDX_W-1:0] idx;
	logic is_write;
	logic [7:0] wdata;
	logic soft_rst;
	logic ctrl_wr;
	logic flag_rd;
	logic [7:0] rd_value;
	logic [FRAME_BITS-1:0] resp;
	logic [7:0] ctrl [0:NREG-1];
	logic [7:0] flag [0:NREG-1];
	logic [7:0] evt [0:NREG-1];

	// set while the frame runs, cleared at once by chip select high
	always_ff @(posedge SCLK or posedge CSN) begin
		if (CSN) begin
			active <= 1'b0;
		end else begin
			active <= 1'b1;
		end
	end

	// bit counter restarts at the first edge, saturates past 16
	always_ff @(posedge SCLK) begin
		if (!active) begin
			rx_cnt <= CNT_W'(1);
		end else if (rx_cnt != CNT_OVER) begin
			rx_cnt <= rx_cnt + CNT_W'(1);
		end
	end

	// lsb first; only the first 16 bits are kept
	always_ff @(posedge SCLK) begin
		if (!active) begin
			rx_frame <= {SDI, rx_frame[FRAME_BITS-1:1]};
		end else if (rx_cnt < CNT_FULL) begin
			rx_frame <= {SDI, rx_frame[FRAME_BITS-1:1]};
		end
	end

	// answer bits change on the falling edge
	always_ff @(negedge SCLK or posedge CSN) begin
		if (CSN) begin
			tx_idx <= 4'h0;
		end else if (tx_idx != 4'hf) begin
			tx_idx <= tx_idx + 4'h1;
		end
	end

	// resp is stable for the whole frame, written only between frames
	assign SDO = resp[tx_idx];
	assign SDO_OE = !CSN;

	// chip select and wake levels pass two flops
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			csn_s1 <= 1'b1;
			csn_s2 <= 1'b1;
			csn_d <= 1'b1;
		end else begin
			csn_s1 <= CSN;
			csn_s2 <= csn_s1;
			csn_d <= csn_s2;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			lvl_s1 <= BYTE_ZERO;
			lvl_s2 <= BYTE_ZERO;
		end else begin
			lvl_s1 <= WAKE_LVL;
			lvl_s2 <= lvl_s1;
		end
	end

	// link registers are quiet once chip select has been high two cycles
	assign take = csn_s2 && !csn_d && (rx_cnt == CNT_FULL);
	assign addr = rx_frame[ADDR_MSB:0];
	assign idx = addr[IDX_W-1:0];
	assign is_write = rx_frame[RW_BIT];
	assign wdata = rx_frame[FRAME_BITS-1:DATA_LSB];

	// mode 11 becomes a soft reset instead of a stored value
	assign soft_rst = take && is_write && (addr == A_MODE_SUPPLY)
		&& (wdata[MODE_HI:MODE_LO] == MODE_SOFT_RST);
	assign ctrl_wr = take && is_write && sbcr_is_ctrl(addr)
		&& !soft_rst;
	// reads never reach the write path
	assign flag_rd = take && !is_write && sbcr_is_flag(addr);

	always_comb begin
		for (int i = 0; i < NREG; i++) begin
			evt[i] = BYTE_ZERO;
		end
		evt[A_SUPPLY_FLG[IDX_W-1:0]] = SUPPLY_EVT;
		evt[A_THERM_FLG[IDX_W-1:0]] = THERMAL_EVT;
		evt[A_DEV_FLG[IDX_W-1:0]] = DEVICE_EVT;
		evt[A_XCVR_FLG[IDX_W-1:0]] = XCVR_EVT;
		evt[A_WAKE_FLG[IDX_W-1:0]] = WAKE_EVT;
		evt[A_LS_OVL_FLG[IDX_W-1:0]] = LS_OVL_EVT;
		evt[A_HS_OVL_FLG[IDX_W-1:0]] = HS_OVL_EVT;
		evt[A_HS_OPEN_FLG[IDX_W-1:0]] = HS_OPEN_EVT;
	end

	// control registers
	always_ff @(posedge MCLK) begin
		if (!RST_N || soft_rst) begin
			for (int i = 0; i < NREG; i++) begin
				ctrl[i] <= sbcr_default(7'(i));
			end
		end else if (RESTART) begin
			for (int i = 0; i < NREG; i++) begin
				// mode bits are not kept, so mode returns to normal
				ctrl[i] <= ctrl[i] & sbcr_keep(7'(i));
			end
		end else begin
			if (ctrl_wr) begin
				ctrl[idx] <= wdata & sbcr_wmask(addr);
			end
			// only the hardware-updatable bits move without a write
			if (VCC2_OFF) begin
				ctrl[A_MODE_SUPPLY[IDX_W-1:0]] <= (ctrl_wr
					&& addr == A_MODE_SUPPLY ? wdata
					& sbcr_wmask(addr) : ctrl[A_MODE_SUPPLY[IDX_W-1:0]])
					& ~VCC2_ON_BITS;
			end
			if (WD_STOP_CLR) begin
				ctrl[A_WDOG[IDX_W-1:0]] <= (ctrl_wr && addr == A_WDOG
					? wdata & sbcr_wmask(addr)
					: ctrl[A_WDOG[IDX_W-1:0]])
					& ~WD_STOP_EN_BIT;
				ctrl[A_WAKE_A[IDX_W-1:0]] <= (ctrl_wr && addr == A_WAKE_A
					? wdata & sbcr_wmask(addr)
					: ctrl[A_WAKE_A[IDX_W-1:0]])
					& ~WAKE_STOP_EN_BIT;
			end
		end
	end

	// read/clear flags; a new event beats the clear of a read
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			for (int i = 0; i < NREG; i++) begin
				flag[i] <= BYTE_ZERO;
			end
			flag[A_SUPPLY_FLG[IDX_W-1:0]] <= SUPPLY_POR_FLAG;
		end else if (soft_rst) begin
			for (int i = 0; i < NREG; i++) begin
				flag[i] <= BYTE_ZERO;
			end
		end else begin
			for (int i = 0; i < NREG; i++) begin
				// mask looked up at the full status address
				if (flag_rd && idx == IDX_W'(i)) begin
					flag[i] <= evt[i]
						& sbcr_fmask(STATUS_BASE | 7'(i));
				end else begin
					flag[i] <= (flag[i] | evt[i])
						& sbcr_fmask(STATUS_BASE | 7'(i));
				end
			end
		end
	end

	// value answered for the addressed register
	always_comb begin
		rd_value = BYTE_ZERO;
		if (sbcr_is_ctrl(addr)) begin
			rd_value = ctrl[idx];
		end else if (sbcr_is_flag(addr)) begin
			rd_value = flag[idx];
		end else if (addr == A_WAKE_LVL) begin
			rd_value = lvl_s2;
		end else if (addr == A_IDENTITY) begin
			rd_value = {FAMILY_CODE, PRODUCT_CODE};
		end
	end

	// answer word shifted out during the next frame
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			resp <= {BYTE_ZERO, BYTE_ZERO};
		end else if (take) begin
			resp <= {rd_value, rx_frame[RW_BIT:0]};
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			SOFT_RESET <= 1'b0;
		end else begin
			SOFT_RESET <= soft_rst;
		end
	end

	assign MODE_SUPPLY_CONTROL = ctrl[A_MODE_SUPPLY[IDX_W-1:0]];
	assign FAILURE_OUTPUT_CONTROL = ctrl[A_FAIL_OUT[IDX_W-1:0]];
	assign WINDOW_WATCHDOG_CONTROL = ctrl[A_WDOG[IDX_W-1:0]];
	assign TRANSCEIVER_CONTROL = ctrl[A_XCVR[IDX_W-1:0]];
	assign WAKE_SOURCE_CONTROL_A = ctrl[A_WAKE_A[IDX_W-1:0]];
	assign WAKE_SOURCE_CONTROL_B = ctrl[A_WAKE_B[IDX_W-1:0]];
	assign WAKE_PULL_CONFIG = ctrl[A_WAKE_PULL[IDX_W-1:0]];
	assign WAKE_FILTER_CONFIG = ctrl[A_WAKE_FILT[IDX_W-1:0]];
	assign CYCLIC_TIMER_A_CONTROL = ctrl[A_TIMER_A[IDX_W-1:0]];
	assign CYCLIC_TIMER_B_CONTROL = ctrl[A_TIMER_B[IDX_W-1:0]];
	assign SWITCH_SHUTDOWN_CONTROL = ctrl[A_SW_SD[IDX_W-1:0]];
	assign LOW_SIDE_SWITCH_CONTROL = ctrl[A_LOW_SIDE[IDX_W-1:0]];
	assign HIGH_SIDE_SWITCH_CONTROL_A = ctrl[A_HIGH_A[IDX_W-1:0]];
	assign HIGH_SIDE_SWITCH_CONTROL_B = ctrl[A_HIGH_B[IDX_W-1:0]];
	assign HIGH_SIDE_SWITCH_CONTROL_C = ctrl[A_HIGH_C[IDX_W-1:0]];
	assign DUTY_CYCLE_CHANNEL_A = ctrl[A_DUTY_A[IDX_W-1:0]];
	assign DUTY_CYCLE_CHANNEL_B = ctrl[A_DUTY_B[IDX_W-1:0]];
	assign DUTY_CYCLE_CHANNEL_C = ctrl[A_DUTY_C[IDX_W-1:0]];
	assign DUTY_CYCLE_CHANNEL_D = ctrl[A_DUTY_D[IDX_W-1:0]];
	assign MODULATION_FREQUENCY_SELECT = ctrl[A_PWM_FREQ[IDX_W-1:0]];
	assign SYSTEM_SCRATCH_STATUS = ctrl[A_SCRATCH[IDX_W-1:0]];

endmodule
`default_nettype wire

// ### testbench/sbcr_register_bank_properties.sv
// port-level assertions of the spi register bank
`timescale 1ns/1ps
`default_nettype none
module sbcr_register_bank_properties (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CSN,
	input wire logic SDO_OE,
	input wire logic RESTART,
	input wire logic VCC2_OFF,
	input wire logic WD_STOP_CLR,
	input wire logic SOFT_RESET,
	input wire logic [7:0] MODE_SUPPLY_CONTROL,
	input wire logic [7:0] FAILURE_OUTPUT_CONTROL,
	input wire logic [7:0] WINDOW_WATCHDOG_CONTROL,
	input wire logic [7:0] WAKE_SOURCE_CONTROL_A,
	input wire logic [7:0] WAKE_PULL_CONFIG,
	input wire logic [7:0] HIGH_SIDE_SWITCH_CONTROL_A,
	input wire logic [7:0] DUTY_CYCLE_CHANNEL_A
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	property p_rst;
		$rose(RST_N) |-> WINDOW_WATCHDOG_CONTROL == 8'h10
			&& MODE_SUPPLY_CONTROL == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("reset defaults");
	property p_soft;
		SOFT_RESET |-> ##[0:2] (MODE_SUPPLY_CONTROL == 8'h00
			&& WINDOW_WATCHDOG_CONTROL == 8'h10);
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset");
	property p_soft_pulse;
		SOFT_RESET |=> !SOFT_RESET;
	endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("pulse");
	property p_keep;
		RESTART && !SOFT_RESET |=> MODE_SUPPLY_CONTROL ==
			($past(MODE_SUPPLY_CONTROL) & 8'h03)
			&& WINDOW_WATCHDOG_CONTROL ==
			($past(WINDOW_WATCHDOG_CONTROL) & 8'h17)
			&& WAKE_PULL_CONFIG == $past(WAKE_PULL_CONFIG);
	endproperty
	a_keep: assert property (p_keep) else $error("restart keep");
	property p_clr;
		RESTART |=> FAILURE_OUTPUT_CONTROL == 8'h00
			&& HIGH_SIDE_SWITCH_CONTROL_A == 8'h00;
	endproperty
	a_clr: assert property (p_clr) else $error("restart clear");
	property p_vcc2;
		VCC2_OFF |=> MODE_SUPPLY_CONTROL[4:3] == 2'h0;
	endproperty
	a_vcc2: assert property (p_vcc2) else $error("vcc2 off");
	property p_wdstop;
		WD_STOP_CLR |=> !WINDOW_WATCHDOG_CONTROL[6]
			&& !WAKE_SOURCE_CONTROL_A[2];
	endproperty
	a_wdstop: assert property (p_wdstop) else $error("wd stop");
	property p_stable;
		!CSN [*3] |=> $stable(DUTY_CYCLE_CHANNEL_A);
	endproperty
	a_stable: assert property (p_stable) else $error("ctrl moved");
	property p_oe;
		SDO_OE == !CSN;
	endproperty
	a_oe: assert property (p_oe) else $error("output enable");
endmodule
`default_nettype wire

// ### testbench/sbcr_spi_master.sv
// spi master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module sbcr_spi_master (
	output logic sclk,
	output logic csn,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		sdi = 1'b0;
	end
	// lsb first, 30 ns clock only in frames; n other than 16 is a bad frame
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		#7 csn = 1'b0;
		for (int k = 0; k < n; k++) begin
			sdi = w[k];
			#15 sclk = 1'b1;
			r[k] = sdo;
			#15 sclk = 1'b0;
		end
		sdi = ~sdi;
		#15 csn = 1'b1;
		// gap lets the bank take the frame
		#200;
	endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench of the spi register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sbcr_pkg::*;
	// identity codes: arbitrary values
	localparam logic [3:0] FAM = 4'h5;
	localparam logic [3:0] PROD = 4'h9;
	localparam logic [6:0] FA [10] = '{A_SUPPLY_FLG, A_THERM_FLG,
		A_DEV_FLG, A_XCVR_FLG, A_WAKE_FLG, A_LS_OVL_FLG, A_HS_OVL_FLG,
		A_HS_OPEN_FLG, A_WAKE_LVL, A_WAKE_FLG};
	localparam logic [7:0] FE [10] = '{8'hff, 8'h1f, 8'hff, 8'h67,
		8'hff, 8'h03, 8'h3f, 8'h3f, 8'h0f, 8'h00};
	localparam logic [6:0] CA [21] = '{A_MODE_SUPPLY, A_FAIL_OUT, A_WDOG,
		A_XCVR, A_WAKE_A, A_WAKE_B, A_WAKE_PULL, A_WAKE_FILT, A_TIMER_A,
		A_TIMER_B, A_SW_SD, A_LOW_SIDE, A_HIGH_A, A_HIGH_B, A_HIGH_C,
		A_DUTY_A, A_DUTY_B, A_DUTY_C, A_DUTY_D, A_PWM_FREQ, A_SCRATCH};
	// writable bits per control register, reserved bits read 0
	localparam logic [7:0] CM [21] = '{8'hdb, 8'h20, 8'h57, 8'hfb, 8'hcc,
		8'h3f, 8'hff, 8'hff, 8'h77, 8'h77, 8'h77, 8'h03, 8'hff, 8'h77,
		8'h77, 8'hff, 8'hff, 8'hff, 8'hff, 8'h55, 8'hff};
	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic RESTART = 1'b0;
	logic VCC2_OFF = 1'b0;
	logic WD_STOP_CLR = 1'b0;
	logic [7:0] lvl = 8'h00;
	logic [7:0] ev [8];
	logic [7:0] c [21];
	logic SCLK, CSN, SDI, SDO, SDO_OE, SOFT_RESET;
	logic [15:0] rsp;
	int fail_count = 0;
	int check_count = 0;
	int soft_seen = 0;
	always #12.5 MCLK = ~MCLK;
	always @(negedge MCLK) if (SOFT_RESET === 1'b1) soft_seen++;
	sbcr_spi_master m (.sclk(SCLK), .csn(CSN), .sdi(SDI), .sdo(SDO));
	sbcr_register_bank #(.FAMILY_CODE(FAM), .PRODUCT_CODE(PROD)) dut (
		.MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK), .CSN(CSN), .SDI(SDI),
		.SDO(SDO), .SDO_OE(SDO_OE), .RESTART(RESTART), .VCC2_OFF(VCC2_OFF),
		.WD_STOP_CLR(WD_STOP_CLR), .SUPPLY_EVT(ev[0]),
		.THERMAL_EVT(ev[1]), .DEVICE_EVT(ev[2]), .XCVR_EVT(ev[3]),
		.WAKE_EVT(ev[4]), .LS_OVL_EVT(ev[5]), .HS_OVL_EVT(ev[6]),
		.HS_OPEN_EVT(ev[7]), .WAKE_LVL(lvl), .SOFT_RESET(SOFT_RESET),
		.MODE_SUPPLY_CONTROL(c[0]), .FAILURE_OUTPUT_CONTROL(c[1]),
		.WINDOW_WATCHDOG_CONTROL(c[2]), .TRANSCEIVER_CONTROL(c[3]),
		.WAKE_SOURCE_CONTROL_A(c[4]), .WAKE_SOURCE_CONTROL_B(c[5]),
		.WAKE_PULL_CONFIG(c[6]), .WAKE_FILTER_CONFIG(c[7]),
		.CYCLIC_TIMER_A_CONTROL(c[8]), .CYCLIC_TIMER_B_CONTROL(c[9]),
		.SWITCH_SHUTDOWN_CONTROL(c[10]), .LOW_SIDE_SWITCH_CONTROL(c[11]),
		.HIGH_SIDE_SWITCH_CONTROL_A(c[12]),
		.HIGH_SIDE_SWITCH_CONTROL_B(c[13]),
		.HIGH_SIDE_SWITCH_CONTROL_C(c[14]), .DUTY_CYCLE_CHANNEL_A(c[15]),
		.DUTY_CYCLE_CHANNEL_B(c[16]), .DUTY_CYCLE_CHANNEL_C(c[17]),
		.DUTY_CYCLE_CHANNEL_D(c[18]), .MODULATION_FREQUENCY_SELECT(c[19]),
		.SYSTEM_SCRATCH_STATUS(c[20]));
	task automatic check(input string n, input logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic fr(input logic [7:0] d, input logic w,
		input logic [6:0] a);
		m.xfer({d, w, a}, 16, rsp);
	endtask
	task automatic tick();
		@(posedge MCLK);
		#2;
	endtask
	task automatic pulse(ref logic s);
		tick();
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask
	task automatic t_reset();
		check("wdog", c[2], 8'h10);
		check("mode", c[0], 8'h00);
		check("oe idle", SDO_OE, 1'b0);
		fr(8'h00, 1'b0, A_SUPPLY_FLG);
		fr(8'h00, 1'b0, A_IDENTITY);
		check("por", rsp, {8'h80, 8'h41});
		fr(8'h00, 1'b0, A_SUPPLY_FLG);
		check("ident", rsp[15:8], {FAM, PROD});
		fr(8'h00, 1'b0, A_SCRATCH);
		check("cleared", rsp[15:8], 8'h00);
	endtask
	task automatic t_rw();
		fr(8'ha5, 1'b1, A_SCRATCH);
		check("scratch", c[20], 8'ha5);
		fr(8'hff, 1'b1, A_LOW_SIDE);
		check("ls", c[11], 8'h03);
		check("echo", rsp, {8'h00, 8'h9e});
		fr(8'h00, 1'b0, A_SCRATCH);
		check("kept", c[20], 8'ha5);
		fr(8'hff, 1'b1, A_SUPPLY_FLG);
		check("read", rsp, {8'ha5, 8'h1e});
		fr(8'h00, 1'b0, A_SUPPLY_FLG);
		fr(8'h00, 1'b0, A_SCRATCH);
		check("rc write", rsp[15:8], 8'h00);
		m.xfer({8'h00, 1'b1, A_SCRATCH}, 15, rsp);
		check("short", c[20], 8'ha5);
	endtask
	task automatic t_hw();
		fr(8'h5b, 1'b1, A_MODE_SUPPLY);
		pulse(VCC2_OFF);
		check("vcc2", c[0], 8'h43);
		fr(8'h00, 1'b0, A_MODE_SUPPLY);
		fr(8'h00, 1'b0, A_SCRATCH);
		check("vcc2 rd", rsp[15:8], 8'h43);
		fr(8'h57, 1'b1, A_WDOG);
		fr(8'h04, 1'b1, A_WAKE_A);
		pulse(WD_STOP_CLR);
		check("wd", c[2], 8'h17);
		check("wk", c[4], 8'h00);
		check("still", c[11], 8'h03);
	endtask
	task automatic t_restart();
		fr(8'h20, 1'b1, A_FAIL_OUT);
		fr(8'hff, 1'b1, A_HIGH_A);
		fr(8'h3c, 1'b1, A_WAKE_PULL);
		fr(8'h57, 1'b1, A_WDOG);
		pulse(RESTART);
		check("mode", c[0], 8'h03);
		check("fo", c[1], 8'h00);
		check("hs", c[12], 8'h00);
		check("pull", c[6], 8'h3c);
		check("wd", c[2], 8'h17);
	endtask
	task automatic t_flags();
		tick();
		lvl = 8'h0f;
		foreach (ev[i]) ev[i] = 8'hff;
		tick();
		foreach (ev[i]) ev[i] = 8'h00;
		for (int i = 0; i < 11; i++) begin
			fr(8'h00, 1'b0, i < 10 ? FA[i] : A_IDENTITY);
			if (i > 0) check("flag", rsp[15:8], FE[i-1]);
		end
	endtask
	task automatic t_soft();
		fr(8'hc0, 1'b1, A_MODE_SUPPLY);
		check("mode", c[0], 8'h00);
		check("wd", c[2], 8'h10);
		check("scr", c[20], 8'h00);
		check("soft out", 16'(soft_seen), 16'h0001);
	endtask
	task automatic t_all();
		logic [7:0] d;
		for (int j = 0; j < 21; j++) begin
			// mode field kept off 11 so no soft reset fires
			d = (j == 0) ? 8'h7f : 8'hff;
			fr(d, 1'b1, CA[j]);
			check("ctrl", c[j], CM[j] & d);
		end
	endtask
	task automatic t_por();
		tick();
		RST_N = 1'b0;
		repeat (10) tick();
		RST_N = 1'b1;
		tick();
		check("por ctrl", c[20], 8'h00);
		check("por wd", c[2], 8'h10);
		fr(8'h00, 1'b0, A_SUPPLY_FLG);
		fr(8'h00, 1'b0, A_SCRATCH);
		check("por flag", rsp[15:8], 8'h80);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		foreach (ev[i]) ev[i] = 8'h00;
		repeat (10) @(posedge MCLK);
		#2 RST_N = 1'b1;
		tick();
		t_reset();
		t_rw();
		t_hw();
		t_restart();
		t_flags();
		t_soft();
		t_all();
		t_por();
		finish_test();
	end
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
endmodule
bind sbcr_register_bank sbcr_register_bank_properties u_prop (.*);
`default_nettype wire
